// ### src/event_interrupt_output.sv
// Attention (interrupt) output sequencer with wake and failure status latches.
// Assumes event strobes and clear strobes come from logic on clk; the
// attention pin level comes from outside and is synchronised here.
// Contract
// - Pulse low 100 us in normal/stop
// - Pulses never change operating mode
// - Class 0 interrupts on wake status only
// - Wake event needs its source enabled
// - Bus timeout gated by own mask
// - Class 1 adds failures, never level status
// - Fatal faults never interrupt
// - Stop entry with uncleared wake events, enabled or not
// - Visible status updates at pulse fall
// - Events latched until read and cleared
// - Init mode samples pin through 7 us filter
module event_interrupt_output
   import event_irq_pkg::*;
(
   input  wire logic              clk,                 // Core clock
   input  wire logic              nrst,                // Async reset, active low
   input  wire logic [1:0]        op_mode,             // Operating mode, read only
   input  wire logic              stop_cmd,            // Pulse: commanded into stop
   input  wire logic              class_global,        // Class select bit
   input  wire logic              bus_timeout_mask,    // Enables bus timeout interrupt
   input  wire logic [WAKE_W-1:0] wake_enable_a,       // Wake sources enabled, reg a
   input  wire logic [WAKE_W-1:0] wake_enable_b,       // Wake sources enabled, reg b
   input  wire logic [WAKE_W-1:0] wake_event_a,        // Wake event strobes, reg a
   input  wire logic [WAKE_W-1:0] wake_event_b,        // Wake event strobes, reg b
   input  wire logic              bus_timeout_event,   // Bus timeout strobe
   input  wire logic [FAIL_W-1:0] fail_event,          // Interrupting failure strobes
   input  wire logic [FAIL_W-1:0] fatal_event,         // Non-interrupting fault strobes
   input  wire logic              clear_wake_a,        // Read-and-clear, reg a
   input  wire logic              clear_wake_b,        // Read-and-clear, reg b
   input  wire logic              clear_fail,          // Read-and-clear, failures
   input  wire logic              clear_fatal,         // Read-and-clear, fatal faults
   input  wire logic              attn_pin_in,         // Attention pin level
   output logic                   attn_out,            // Attention pin drive value
   output logic                   attn_oe_n,           // Drive enable, low drives
   output logic [WAKE_W-1:0]      wake_status_reg_a,   // Visible wake status a
   output logic [WAKE_W-1:0]      wake_status_reg_b,   // Visible wake status b
   output logic [FAIL_W-1:0]      fail_status,         // Visible failure status
   output logic [FAIL_W-1:0]      fatal_status,        // Visible fatal fault status
   output logic                   hw_config            // Filtered config level
);
   // Internal latches and pulse sequencer state
   logic [WAKE_W-1:0] wa_reg, wa_next;       // Latched wake events a
   logic [WAKE_W-1:0] wb_reg, wb_next;       // Latched wake events b
   logic [FAIL_W-1:0] fl_reg, fl_next;       // Latched failures
   logic [FAIL_W-1:0] ft_reg, ft_next;       // Latched fatal faults
   logic [WAKE_W-1:0] va_reg, va_next;       // Visible copy a
   logic [WAKE_W-1:0] vb_reg, vb_next;       // Visible copy b
   logic [FAIL_W-1:0] vf_reg, vf_next;       // Visible copy failures
   logic [FAIL_W-1:0] vt_reg, vt_next;       // Visible copy fatal
   logic              pend_reg, pend_next;   // Interrupt waiting for a pulse
   pulse_state_t      st_reg, st_next;       // Sequencer state
   logic [TIMER_W-1:0] tmr_reg, tmr_next;    // Phase timer
   logic              out_reg, out_next;     // Pin drive value
   logic              oe_n_reg, oe_n_next;   // Pin drive enable, low active
   logic              sync1_reg, sync2_reg;  // Pin synchroniser
   logic              cfg_reg, cfg_next;     // Registered config level
   logic              cfg_filt;              // Filter output
   logic [WAKE_W-1:0] irq_a, irq_b;          // Interrupting wake bits
   logic              irq_fail;              // Interrupting failure
   logic              new_irq;               // Any new interrupt this cycle
   logic              pulse_mode;            // Modes that pulse the pin

   // Mask wake bits by enable; bus timeout bit uses its own mask
   function automatic logic [WAKE_W-1:0] wake_gate(
      input logic [WAKE_W-1:0] ev,
      input logic [WAKE_W-1:0] en,
      input logic              to_slot,
      input logic              to_mask
   );
      logic [WAKE_W-1:0] g;
      g = ev & en;
      if (to_slot) begin
         g[TO_BIT] = ev[TO_BIT] & to_mask;
      end
      return g;
   endfunction : wake_gate

   // Pin synchroniser, two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= attn_pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Config level filter, active only in init mode
   cfg_pin_filter u_cfg_filter (
      .clk       (clk),
      .nrst      (nrst),
      .enable    (op_mode == MODE_INIT),
      .level_in  (sync2_reg),
      .level_out (cfg_filt)
   );

   // Interrupt source decode; fatal faults never feed it
   always_comb begin
      logic [WAKE_W-1:0] eb;
      eb = wake_event_b;
      eb[TO_BIT] = bus_timeout_event;
      irq_a    = wake_gate(wake_event_a, wake_enable_a, 1'b0, 1'b0);
      irq_b    = wake_gate(eb, wake_enable_b, 1'b1, bus_timeout_mask);
      irq_fail = class_global && (|fail_event);
      new_irq  = (|irq_a) || (|irq_b) || irq_fail
                 || (stop_cmd && ((|wa_reg) || (|wb_reg)));
   end

   // Status latches: set wins over clear
   always_comb begin
      logic [WAKE_W-1:0] eb;
      eb = wake_event_b;
      eb[TO_BIT] = bus_timeout_event;
      wa_next = (clear_wake_a ? '0 : wa_reg) | wake_event_a;
      wb_next = (clear_wake_b ? '0 : wb_reg) | eb;
      fl_next = (clear_fail ? '0 : fl_reg) | fail_event;
      ft_next = (clear_fatal ? '0 : ft_reg) | fatal_event;
   end

   // Pulse sequencer; mode is only read, never written
   always_comb begin
      pulse_mode = (op_mode == MODE_NORMAL) || (op_mode == MODE_STOP);
      st_next   = st_reg;
      tmr_next  = tmr_reg;
      pend_next = pend_reg || new_irq;
      out_next  = 1'b1;
      oe_n_next = (op_mode == MODE_INIT);                 // Release in init
      va_next   = va_reg;
      vb_next   = vb_reg;
      vf_next   = vf_reg;
      vt_next   = vt_reg;
      // Cleared bits vanish from the visible copy at once
      if (clear_wake_a) va_next = '0;
      if (clear_wake_b) vb_next = '0;
      if (clear_fail)   vf_next = '0;
      if (clear_fatal)  vt_next = '0;
      case (st_reg)
         // Wait for a pending interrupt
         ST_IDLE: begin
            if (pend_reg && pulse_mode) begin
               st_next   = ST_LOW;
               tmr_next  = '0;
               pend_next = new_irq;
               out_next  = 1'b0;
               va_next   = wa_next;
               vb_next   = wb_next;
               vf_next   = fl_next;
               vt_next   = ft_next;
            end
         end
         // Pin held low for the pulse width
         ST_LOW: begin
            out_next = 1'b0;
            tmr_next = tmr_reg + TIMER_W'(1);
            // Entry edge counts as the first low cycle, so release after W-1 more
            if (tmr_reg == TIMER_W'(PULSE_WIDTH_CYC - 1)) begin
               st_next  = ST_GAP;
               tmr_next = '0;
               out_next = 1'b1;
            end
         end
         // Least high time before the next pulse
         ST_GAP: begin
            tmr_next = tmr_reg + TIMER_W'(1);
            if (tmr_reg == TIMER_W'(PULSE_GAP_CYC - 2)) begin
               st_next  = ST_IDLE;
               tmr_next = '0;
            end
         end
         default: begin
            st_next  = ST_IDLE;
            tmr_next = '0;
         end
      endcase
      cfg_next = cfg_filt;
   end

   // State registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wa_reg   <= '0;
         wb_reg   <= '0;
         fl_reg   <= '0;
         ft_reg   <= '0;
         va_reg   <= '0;
         vb_reg   <= '0;
         vf_reg   <= '0;
         vt_reg   <= '0;
         pend_reg <= 1'b0;
         st_reg   <= ST_IDLE;
         tmr_reg  <= '0;
         out_reg  <= 1'b1;
         oe_n_reg <= 1'b1;
         cfg_reg  <= 1'b0;
      end else begin
         wa_reg   <= wa_next;
         wb_reg   <= wb_next;
         fl_reg   <= fl_next;
         ft_reg   <= ft_next;
         va_reg   <= va_next;
         vb_reg   <= vb_next;
         vf_reg   <= vf_next;
         vt_reg   <= vt_next;
         pend_reg <= pend_next;
         st_reg   <= st_next;
         tmr_reg  <= tmr_next;
         out_reg  <= out_next;
         oe_n_reg <= oe_n_next;
         cfg_reg  <= cfg_next;
      end
   end

   // Outputs straight from flops
   assign attn_out          = out_reg;
   assign attn_oe_n         = oe_n_reg;
   assign wake_status_reg_a = va_reg;
   assign wake_status_reg_b = vb_reg;
   assign fail_status       = vf_reg;
   assign fatal_status      = vt_reg;
   assign hw_config         = cfg_reg;
endmodule : event_interrupt_output

// ### shared/event_irq_pkg.sv
// Constants for the event interrupt output block.
// Assumes a 250 MHz core clock; all times are converted to cycles here.
package event_irq_pkg;
   localparam int CLK_MHZ          = 250;     // Core clock rate
   localparam int PULSE_WIDTH_US   = 100;     // Low time of one pulse
   localparam int PULSE_GAP_US     = 100;     // Least high time between pulses
   localparam int CFG_FILTER_US    = 7;       // Config pin filter time
   localparam int PULSE_WIDTH_CYC  = PULSE_WIDTH_US * CLK_MHZ;
   localparam int PULSE_GAP_CYC    = PULSE_GAP_US * CLK_MHZ;
   localparam int CFG_FILTER_CYC   = CFG_FILTER_US * CLK_MHZ;
   localparam int TIMER_W          = 16;      // Width of the pulse timer
   localparam int FILT_W           = 11;      // Width of the filter counter
   localparam int WAKE_W           = 8;       // Bits per wake status register
   localparam int FAIL_W           = 8;       // Bits of other failure status
   localparam int TO_BIT           = 0;       // Bus timeout position in register b
   localparam logic [1:0] MODE_INIT   = 2'h0; // Operating mode encodings
   localparam logic [1:0] MODE_NORMAL = 2'h1;
   localparam logic [1:0] MODE_STOP   = 2'h2;
   localparam logic [1:0] MODE_OTHER  = 2'h3;
   // Pulse sequencer states, Gray coded along idle-low-gap
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW  = 2'b01,
      ST_GAP  = 2'b11
   } pulse_state_t;
endpackage : event_irq_pkg

// ### src/cfg_pin_filter.sv
// Debounce filter for the attention pin level sampled in init mode.
// Assumes the input is already synchronised to clk.
module cfg_pin_filter
   import event_irq_pkg::*;
(
   input  wire logic clk,           // Core clock
   input  wire logic nrst,          // Async reset, active low
   input  wire logic enable,        // Filter runs only while high
   input  wire logic level_in,      // Synchronised pin level
   output logic      level_out      // Filtered level
);
   logic [FILT_W-1:0] cnt_reg, cnt_next;   // Stable-time counter
   logic              out_reg, out_next;   // Accepted level

   // Accept a new level after it stays stable the whole filter time
   always_comb begin
      cnt_next = cnt_reg;
      out_next = out_reg;
      if (!enable || level_in == out_reg) begin
         cnt_next = '0;
      end else if (cnt_reg == FILT_W'(CFG_FILTER_CYC - 1)) begin
         out_next = level_in;
         cnt_next = '0;
      end else begin
         cnt_next = cnt_reg + FILT_W'(1);
      end
   end

   // State registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign level_out = out_reg;
endmodule : cfg_pin_filter

// ### sim/event_irq_properties.sv
// Checker of the attention pulse timing and the wake status latches.
// Bound onto event_interrupt_output; sees only its ports.
module event_irq_checker
   import event_irq_pkg::*;
(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic [1:0]        op_mode,
   input wire logic              stop_cmd,
   input wire logic              class_global,
   input wire logic [WAKE_W-1:0] wake_event_a,
   input wire logic [WAKE_W-1:0] wake_enable_a,
   input wire logic              clear_wake_a,
   input wire logic              attn_out,
   input wire logic              attn_oe_n,
   input wire logic [WAKE_W-1:0] wake_status_reg_a,
   input wire logic [WAKE_W-1:0] wake_status_reg_b,
   input wire logic [FAIL_W-1:0] fail_status
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] lo_reg, lo_next, hi_reg, hi_next; // Low run, saturating high run
   // Count the current low and high runs of the drive value
   always_comb begin
      lo_next = attn_out ? 16'h0000 : lo_reg + 16'h0001;
      hi_next = attn_out ? hi_reg + {15'h0000, ~&hi_reg} : 16'h0000;
   end
   // Register the run counters; high run starts saturated
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) {lo_reg, hi_reg} <= {16'h0000, 16'hFFFF};
      else {lo_reg, hi_reg} <= {lo_next, hi_next};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Still high one cycle on, low the next
   sequence s_fall_in_two; ##1 attn_out ##1 !attn_out; endsequence
   property p_width; $rose(attn_out) |-> lo_reg == PULSE_WIDTH_CYC; endproperty
   a_width: assert property (p_width) else $error("pulse width wrong");
   property p_gap; $fell(attn_out) |-> hi_reg >= PULSE_GAP_CYC; endproperty
   a_gap: assert property (p_gap) else $error("gap too short");
   property p_wake; (wake_event_a & wake_enable_a) != '0 && op_mode == MODE_NORMAL
      && attn_out && hi_reg > PULSE_GAP_CYC + 4 |-> s_fall_in_two; endproperty
   a_wake: assert property (p_wake) else $error("wake pulse late");
   property p_stop; stop_cmd && (wake_status_reg_a | wake_status_reg_b) != '0
      && attn_out && hi_reg > PULSE_GAP_CYC + 4 |-> s_fall_in_two; endproperty
   a_stop: assert property (p_stop) else $error("stop pulse missing");
   property p_cause; $fell(attn_out) |-> (wake_status_reg_a | wake_status_reg_b) != '0
      || class_global && fail_status != '0; endproperty
   a_cause: assert property (p_cause) else $error("pulse without cause");
   property p_oe; 1'b1 |=> attn_oe_n == ($past(op_mode) == MODE_INIT); endproperty
   a_oe: assert property (p_oe) else $error("drive enable wrong");
   property p_clear; clear_wake_a |=> wake_status_reg_a == '0 || $fell(attn_out); endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
   property p_hold; $changed(wake_status_reg_a) |-> $fell(attn_out) || $past(clear_wake_a);
   endproperty
   a_hold: assert property (p_hold) else $error("status moved");
endmodule : event_irq_checker
bind event_interrupt_output event_irq_checker chk (.clk, .nrst, .op_mode, .stop_cmd,
   .class_global, .wake_event_a, .wake_enable_a, .clear_wake_a, .attn_out, .attn_oe_n,
   .wake_status_reg_a, .wake_status_reg_b, .fail_status);

// ### sim/host_mcu_model.sv
// Host side of the attention pin: wire level and read-and-clear of wake a.
// Assumes the strap level models the pin while the device releases it.
module host_mcu_model #(
   parameter int CLR_DELAY = 8 // Host reaction after a pulse ends
) (
   input  wire logic clk,
   input  wire logic attn_out,
   input  wire logic attn_oe_n,
   input  wire logic cfg_level,
   output logic      pin_level,
   output logic      clear_a
);
   timeunit 1ns;
   timeprecision 1ps;
   int   wait_cnt = 0;    // Cycles left to the clear strobe
   logic last_pin = 1'b1; // Pin level one cycle back
   // Device drives when enabled, else the strap sets the level
   assign pin_level = attn_oe_n ? cfg_level : attn_out;
   // First read-and-clear, then a confirming second read two cycles on
   assign clear_a = (wait_cnt == 3) || (wait_cnt == 1);
   // Start the clear countdown at each pulse end
   always @(negedge clk) begin
      if (pin_level && !last_pin) wait_cnt <= CLR_DELAY;
      else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      last_pin <= pin_level;
   end
endmodule : host_mcu_model

// ### sim/test_event_interrupt_output.sv
// Self-checking bench for the attention pulse sequencer.
// Assumes the host model on the pin and the package constants.
module test_event_interrupt_output
   import event_irq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, nrst, stop_cmd, class_global, bus_timeout_mask, bus_timeout_event;
   logic clr_a, clear_wake_b, clear_fail, clear_fatal, cfg_level, pin_level, mcu_clr;
   logic attn_out, attn_oe_n, hw_config, last_out = 1'b1;
   logic [1:0]        op_mode;
   logic [WAKE_W-1:0] wake_enable_a, wake_enable_b, wake_event_a, wake_event_b, ev;
   logic [WAKE_W-1:0] wake_status_reg_a, wake_status_reg_b;
   logic [FAIL_W-1:0] fail_event, fatal_event, fail_status, fatal_status, fv, xv;
   logic [31:0]       exp_q[$]; // Status expected at each pulse fall
   int num_errors = 0, checks_done = 0, seed = 32'hA037, low_run = 0;
   event_interrupt_output dut (.clk, .nrst, .op_mode, .stop_cmd, .class_global,
      .bus_timeout_mask, .wake_enable_a, .wake_enable_b, .wake_event_a, .wake_event_b,
      .bus_timeout_event, .fail_event, .fatal_event, .clear_wake_a(clr_a | mcu_clr),
      .clear_wake_b, .clear_fail, .clear_fatal, .attn_pin_in(pin_level), .attn_out,
      .attn_oe_n, .wake_status_reg_a, .wake_status_reg_b, .fail_status, .fatal_status,
      .hw_config);
   host_mcu_model host (.clk, .attn_out, .attn_oe_n, .cfg_level, .pin_level,
      .clear_a(mcu_clr));
   always #2 clk = ~clk;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // Wait, bounded, for the drive value to reach a level
   task automatic wait_out(input logic v);
      for (int i = 0; i < 30000 && attn_out !== v; i++) @(negedge clk);
      cmp(attn_out, v);
   endtask : wait_out
   // One-cycle event strobes, then the pulse must start on the second edge
   task automatic fire(input logic [7:0] w, input logic t, input logic s);
      {wake_event_a, bus_timeout_event, stop_cmd} = {w, t, s};
      tick(1);
      {wake_event_a, bus_timeout_event, stop_cmd} = '0;
      cmp(attn_out, 1'b1);
      tick(1);
      cmp(attn_out, 1'b0);
   endtask : fire
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // Monitor: status at each fall, width at each rise
   always @(negedge clk) begin
      if (!attn_out && last_out) begin
         if (exp_q.size() == 0) cmp(32'h0, 32'h1);
         else cmp({wake_status_reg_a, wake_status_reg_b, fail_status, fatal_status},
            exp_q.pop_front());
      end
      if (attn_out && !last_out) cmp(low_run, PULSE_WIDTH_CYC);
      low_run = attn_out ? 0 : low_run + 1;
      last_out = attn_out;
   end
   // Watchdog against a hang
   initial begin
      repeat (140000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      {nrst, stop_cmd, class_global, bus_timeout_mask, bus_timeout_event} = '0;
      {clr_a, clear_wake_b, clear_fail, clear_fatal, wake_enable_a} = '0;
      {wake_event_a, wake_event_b, fail_event, fatal_event} = '0;
      {wake_enable_b, op_mode, cfg_level} = {8'hFF, MODE_INIT, 1'b1};
      tick(3);
      nrst = 1'b1;
      tick(1800);
      cmp(hw_config, 1'b1);
      cmp(attn_oe_n, 1'b1);
      {ev, fv, xv} = 24'($random(seed)) | 24'h010100;
      op_mode = MODE_NORMAL;
      {wake_event_a, fail_event, fatal_event, bus_timeout_event} = {ev, fv, xv, 1'b1};
      tick(1);
      {wake_event_a, fail_event, fatal_event, bus_timeout_event} = '0;
      tick(20);
      cmp(attn_out, 1'b1);
      {clr_a, clear_wake_b, clear_fail, clear_fatal} = 4'hF;
      tick(1);
      {clr_a, clear_wake_b, clear_fail, clear_fatal} = 4'h0;
      {class_global, bus_timeout_mask, wake_enable_a} = {2'h3, ev};
      exp_q.push_back({ev, 8'h01 << TO_BIT, 8'h00, 8'h00});
      fire(ev, 1'b1, 1'b0);
      tick(100);
      {fail_event, fatal_event} = {fv, xv};
      tick(1);
      {fail_event, fatal_event} = '0;
      exp_q.push_back({8'h00, 8'h01 << TO_BIT, fv, xv});
      wait_out(1'b1);
      wait_out(1'b0);
      wait_out(1'b1);
      {clear_fail, clear_fatal} = 2'h3;
      tick(1);
      {clear_fail, clear_fatal} = 2'h0;
      tick(PULSE_GAP_CYC + 10);
      op_mode = MODE_STOP;
      exp_q.push_back({8'h00, 8'h01 << TO_BIT, 8'h00, 8'h00});
      fire(8'h00, 1'b0, 1'b1);
      tick(5);
      cmp(exp_q.size(), 32'h0);
      tally_and_finish();
   end
endmodule : test_event_interrupt_output
